/* File: logic/chk_pkg.sv */
// package for the program image checksum block
// assumes one 250 MHz clock domain shared by all users of these constants
package chk_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int unsigned WORD_W = 14;        // program memory word
  localparam int unsigned SUM_W  = 16;        // checksum width
  localparam int unsigned ADDR_W = 14;        // word address counter
  localparam int unsigned NIB_W  = 4;         // kept bits of an id location
  localparam int unsigned FIFO_W = 15;        // last flag plus word
  localparam int unsigned FIFO_D = 16;        // buffer depth in words

  // ------------------------------------------------------------
  // masks and reset values
  // ------------------------------------------------------------
  localparam logic [WORD_W-1:0] CFG_MASK  = 14'h3BFF;   // config word mask
  localparam logic [NIB_W-1:0]  ID_MASK   = 4'hF;       // id location mask
  localparam logic [SUM_W-1:0]  SUM_RST   = 16'h0000;   // accumulator clear
  localparam logic [ADDR_W-1:0] ADDR_RST  = 14'h0000;   // first address
  localparam logic [ADDR_W-1:0] ADDR_LAST = 14'h3FFF;   // counter saturates

  // ------------------------------------------------------------
  // exclusive upper bounds of the summed range (image mode)
  // ------------------------------------------------------------
  localparam logic [ADDR_W:0] BND_SMALL_OFF = 15'h0800;  // 0..0x07FF
  localparam logic [ADDR_W:0] BND_LARGE_OFF = 15'h1800;  // 0..0x17FF
  localparam logic [ADDR_W:0] BND_4K_HALF   = 15'h0800;  // upper half protected
  localparam logic [ADDR_W:0] BND_4K_TOP    = 15'h0F00;  // top block protected
  localparam logic [ADDR_W:0] BND_8K_HALF   = 15'h1000;
  localparam logic [ADDR_W:0] BND_8K_TOP    = 15'h1F00;
  localparam logic [ADDR_W:0] BND_NONE      = 15'h0000;  // nothing summed

  // ------------------------------------------------------------
  // protection field inside the config word
  // ------------------------------------------------------------
  localparam int unsigned   CP_LSB  = 12;      // two bits, 13:12
  localparam logic [1:0]    CP_OFF  = 2'h3;
  localparam logic [1:0]    CP_TOP  = 2'h2;
  localparam logic [1:0]    CP_HALF = 2'h1;
  localparam logic [1:0]    CP_ALL  = 2'h0;

  // memory size of the variant being checked
  typedef enum logic [1:0] {MEM_2K, MEM_4K, MEM_8K} mem_kind_t;

  // sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_SUM, ST_CFG, ST_ID} chk_state_t;

endpackage

/* File: logic/word_fifo.sv */
// synchronous fifo with valid/ready on both sides
// assumes writer and reader share clk_i; reset is synchronous, active low
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int unsigned W = 15,                 // word width
  parameter int unsigned D = 16                  // depth, power of two
) (
  input  wire logic         clk_i,               // clock
  input  wire logic         rst_n_i,             // sync reset, low
  input  wire logic         in_valid_i,          // writer offers a word
  output logic              in_ready_o,          // room for a word
  input  wire logic [W-1:0] in_data_i,           // word written
  output logic              out_valid_o,         // word available
  input  wire logic         out_ready_i,         // reader takes it
  output logic      [W-1:0] out_data_o           // head word
);
  localparam int unsigned P = $clog2(D);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [P-1:0] wr;                            // write pointer
    logic [P-1:0] rd;                            // read pointer
    logic [P:0]   cnt;                           // words held
  } fifo_st_t;

  fifo_st_t   s_q, s_d;
  logic [W-1:0] mem_q [D];                       // storage, no reset needed
  logic       push, pop;

  // full and empty straight from the count
  assign in_ready_o  = (s_q.cnt != (P+1)'(D));
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o  = mem_q[s_q.rd];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // next pointers and count
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  // register state
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[s_q.wr] <= in_data_i;
    end
  end

  // never count past the depth
  count_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_q.cnt <= (P+1)'(D)) else $error("fifo count above depth");
endmodule
`default_nettype wire

/* File: logic/image_checksum.sv */
// program image checksum: sums the streamed program words, then the masked
// config word, then the packed id term when protection is on
// assumes words arrive in address order from 0, the last one flagged, and
// that config and id inputs are stable at the start pulse
//
// Function
// - add each covered program word to total
// - drop carries, report low 16 bits
// - id term: four low nibbles, first highest
// - large, unprotected: words 0..0x17FF plus config
// - small, unprotected: words 0..0x07FF plus config
// - all protected: config plus id only
// - 4K half protected: 0..0x07FF, config, id
// - read-back: sum every word as read
// - config and id always taken as read
// - protected read-back words count as zero
`timescale 1ns/1ps
`default_nettype none
module image_checksum
  import chk_pkg::*;
(
  input  wire logic                      clk_i,               // 250 MHz clock
  input  wire logic                      rst_n_i,             // sync reset, low
  input  wire logic                      start_i,             // begin a new sum
  input  wire logic                      readback_i,          // words come from a device
  input  wire chk_pkg::mem_kind_t        mem_kind_i,          // variant memory size
  input  wire logic [chk_pkg::WORD_W-1:0] config_word_value_i, // config word as read
  input  wire logic [chk_pkg::WORD_W-1:0] first_id_location_i, // id location 0
  input  wire logic [chk_pkg::WORD_W-1:0] second_id_location_i,// id location 1
  input  wire logic [chk_pkg::WORD_W-1:0] third_id_location_i, // id location 2
  input  wire logic [chk_pkg::WORD_W-1:0] fourth_id_location_i,// id location 3
  input  wire logic                      word_valid_i,        // program word offered
  output logic                           word_ready_o,        // buffer has room
  input  wire logic [chk_pkg::WORD_W-1:0] word_data_i,         // program word
  input  wire logic                      word_last_i,         // last word of image
  output logic                           busy_o,              // sum in progress
  output logic                           done_o,              // one-cycle completion
  output logic [chk_pkg::SUM_W-1:0]      checksum_o           // held result
);
  import chk_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    chk_state_t        st;        // sequencer
    logic [SUM_W-1:0]  acc;       // running total
    logic [ADDR_W-1:0] addr;      // address of next word
    logic [ADDR_W:0]   bound;     // words below this are summed
    logic              rdbk;      // read-back source
    logic              use_id;    // id term wanted
    logic [WORD_W-1:0] cfg;       // masked config captured at start
    logic [SUM_W-1:0]  idt;       // packed id term captured at start
    logic [SUM_W-1:0]  res;       // reported checksum
    logic              done;      // completion pulse
  } chk_st_t;

  chk_st_t            s_q, s_d;
  logic               f_valid;    // buffered word present
  logic               f_ready;    // sequencer drains it
  logic [FIFO_W-1:0]  f_data;     // {last, word}
  logic [SUM_W-1:0]   packed_id_term;
  logic [ADDR_W:0]    bound_sel;  // range chosen from protection
  logic [1:0]         cp;         // protection code of config word
  logic               covered;    // current head word is summed
  logic               pop;        // head word consumed

  // ------------------------------------------------------------
  // input buffer
  // ------------------------------------------------------------
  // back-pressure: the sequencer only drains while summing, so a source
  // that streams before start stalls once sixteen words are queued
  word_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (word_valid_i),
    .in_ready_o  (word_ready_o),
    .in_data_i   ({word_last_i, word_data_i}),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready),
    .out_data_o  (f_data)
  );

  // ------------------------------------------------------------
  // id term and range
  // ------------------------------------------------------------
  // id nibbles, first location in the top nibble
  assign packed_id_term = {first_id_location_i[NIB_W-1:0] & ID_MASK,
                           second_id_location_i[NIB_W-1:0] & ID_MASK,
                           third_id_location_i[NIB_W-1:0] & ID_MASK,
                           fourth_id_location_i[NIB_W-1:0] & ID_MASK};

  assign cp = config_word_value_i[CP_LSB+1:CP_LSB];

  // summed range per protection code and memory size
  always_comb begin
    bound_sel = BND_NONE;
    case (cp)
      CP_OFF: begin
        // 2K and 4K parts both stop at 0x07FF when unprotected
        bound_sel = (mem_kind_i == MEM_8K) ? BND_LARGE_OFF : BND_SMALL_OFF;
      end
      CP_TOP: begin
        bound_sel = (mem_kind_i == MEM_8K) ? BND_8K_TOP : BND_4K_TOP;
      end
      CP_HALF: begin
        bound_sel = (mem_kind_i == MEM_8K) ? BND_8K_HALF : BND_4K_HALF;
      end
      CP_ALL: begin
        bound_sel = BND_NONE;
      end
      default: begin
        bound_sel = BND_NONE;
      end
    endcase
  end

  // read-back sums everything; image mode masks off the protected range
  assign covered = s_q.rdbk || ({1'b0, s_q.addr} < s_q.bound);
  assign f_ready = (s_q.st == ST_SUM);
  assign pop     = f_ready & f_valid;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (start_i) begin
          s_d.st     = ST_SUM;
          s_d.acc    = SUM_RST;
          s_d.addr   = ADDR_RST;
          s_d.bound  = bound_sel;
          s_d.rdbk   = readback_i;
          s_d.use_id = (cp != CP_OFF);
          s_d.cfg    = config_word_value_i & CFG_MASK;
          s_d.idt    = packed_id_term;
        end
      end
      ST_SUM: begin
        if (pop) begin
          // protected words read back as zero and add nothing
          if (covered) begin
            s_d.acc = s_q.acc + SUM_W'(f_data[WORD_W-1:0]);
          end
          if (s_q.addr != ADDR_LAST) begin
            s_d.addr = s_q.addr + 1'b1;
          end
          if (f_data[FIFO_W-1]) begin
            s_d.st = ST_CFG;
          end
        end
      end
      ST_CFG: begin
        s_d.acc = s_q.acc + SUM_W'(s_q.cfg);
        if (s_q.use_id) begin
          s_d.st = ST_ID;
        end else begin
          s_d.st   = ST_IDLE;
          s_d.res  = s_q.acc + SUM_W'(s_q.cfg);
          s_d.done = 1'b1;
        end
      end
      ST_ID: begin
        s_d.acc  = s_q.acc + s_q.idt;
        s_d.res  = s_q.acc + s_q.idt;
        s_d.done = 1'b1;
        s_d.st   = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  // register state
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q       <= '0;
      s_q.st    <= ST_IDLE;
      s_q.acc   <= SUM_RST;
      s_q.addr  <= ADDR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_o     = (s_q.st != ST_IDLE);
  assign done_o     = s_q.done;
  assign checksum_o = s_q.res;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence cfg_step_s;
    (s_q.st == ST_CFG) && s_q.use_id;
  endsequence

  sequence id_step_s;
    ##1 (s_q.st == ST_ID) ##1 done_o;
  endsequence

  start_clears_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == ST_IDLE && start_i) |=> (s_q.acc == 16'h0000) && busy_o)
    else $error("start did not clear the total");

  word_added_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pop && covered) |=> s_q.acc == $past(s_q.acc) + SUM_W'($past(f_data[WORD_W-1:0])))
    else $error("covered word not added");

  word_skipped_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pop && !covered) |=> $stable(s_q.acc))
    else $error("uncovered word changed total");

  range_limit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pop && covered && !s_q.rdbk && !s_q.use_id) |-> (s_q.addr <= 14'h17FF))
    else $error("word above range summed");

  all_protect_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == ST_SUM && !s_q.rdbk && s_q.bound == 15'h0000) |-> !covered)
    else $error("word summed with all protected");

  readback_all_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == ST_SUM && s_q.rdbk) |-> covered)
    else $error("read-back word excluded");

  cfg_added_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == ST_CFG) |=> s_q.acc == $past(s_q.acc) + SUM_W'($past(s_q.cfg) & 14'h3BFF))
    else $error("masked config not added");

  id_then_done_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_step_s |-> id_step_s)
    else $error("id step or completion missing");

  result_held_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done_o |-> (checksum_o == s_q.acc) && !busy_o)
    else $error("result differs from total");

  half_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == ST_IDLE && start_i && cp == 2'h1 && mem_kind_i == MEM_4K)
      |=> (s_q.bound == 15'h0800) && s_q.use_id)
    else $error("half protection range wrong");
endmodule
`default_nettype wire

/* File: sim/word_source.sv */
// partner model: programmer streaming program words into the checksum block
// assumes one clock shared with the block; reset synchronous, active low
`timescale 1ns/1ps
`default_nettype none
module word_source (
  input  wire logic        clk_i,        // clock
  input  wire logic        rst_n_i,      // sync reset, low
  input  wire logic        load_i,       // begin a new stream
  input  wire logic [15:0] count_i,      // words in the stream
  input  wire logic [13:0] base_i,       // seed of the word pattern
  input  wire logic [15:0] zero_from_i,  // first index read back as zero
  input  wire logic        stall_i,      // hold off the next offer
  input  wire logic        ready_i,      // block takes the word
  output logic             valid_o,      // word offered
  output logic      [13:0] data_o,       // program word
  output logic             last_o        // last word flag
);
  // ----------------------------------------
  // stream state
  // ----------------------------------------
  logic        act_q;   // words left to send
  logic        val_q;   // offer standing
  logic [15:0] idx_q;   // address of the offered word
  logic [15:0] cnt_q;   // stream length
  logic [13:0] base_q;  // pattern seed
  logic [15:0] zf_q;    // protected area start
  logic [13:0] word_w;  // word at idx_q
  logic        end_w;   // offered word is the last

  // words at or above zf_q read back as zero, as a protected device does
  always_comb begin
    word_w = base_q + 14'(idx_q * 16'h0155);
    if (idx_q >= zf_q) begin
      word_w = 14'h0000;
    end
  end
  assign end_w   = (idx_q == cnt_q - 16'h0001);
  assign valid_o = val_q;
  // released lines show the inverse, so a stale value never passes
  assign data_o  = val_q ? word_w : ~word_w;
  assign last_o  = val_q ? end_w : ~end_w;

  // offer held until taken; stall only delays the next offer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      act_q <= 1'b0;
      val_q <= 1'b0;
      idx_q <= 16'h0000;
    end else if (load_i) begin
      act_q  <= 1'b1;
      val_q  <= 1'b0;
      idx_q  <= 16'h0000;
      cnt_q  <= count_i;
      base_q <= base_i;
      zf_q   <= zero_from_i;
    end else if (val_q && ready_i) begin
      idx_q <= idx_q + 16'h0001;
      act_q <= !end_w;
      val_q <= !end_w && !stall_i;
    end else if (!val_q && act_q && !stall_i) begin
      val_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// testbench for the program image checksum block
// assumes the partner model word_source; one 250 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb;
  import chk_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, rb = 1'b0, load = 1'b0, stall = 1'b0, stall_en = 1'b1;
  mem_kind_t kind = MEM_2K;
  logic [13:0] cfg = 14'h0000, id0 = 14'h0000, id1 = 14'h0000, id2 = 14'h0000, id3 = 14'h0000;
  logic [13:0] base = 14'h0000, w_data;
  logic [15:0] cnt = 16'h0001, zf = 16'hFFFF, sum;
  logic w_valid, w_ready, w_last, busy, done;
  int seed = 95;
  int fail_count = 0;
  int n_checks = 0;

  always #2 clk = ~clk;  // 4 ns period
  // random far-side stall, switched off when a fill must be deterministic
  always @(posedge clk) stall <= stall_en && ($random(seed) % 4 == 0);

  image_checksum image_checksum_i (.clk_i(clk), .rst_n_i(rst_n), .start_i(start), .readback_i(rb),
    .mem_kind_i(kind), .config_word_value_i(cfg), .first_id_location_i(id0), .second_id_location_i(id1),
    .third_id_location_i(id2), .fourth_id_location_i(id3), .word_valid_i(w_valid), .word_ready_o(w_ready),
    .word_data_i(w_data), .word_last_i(w_last), .busy_o(busy), .done_o(done), .checksum_o(sum));
  word_source word_source_i (.clk_i(clk), .rst_n_i(rst_n), .load_i(load), .count_i(cnt), .base_i(base),
    .zero_from_i(zf), .stall_i(stall), .ready_i(w_ready), .valid_o(w_valid), .data_o(w_data), .last_o(w_last));

  // ----------------------------------------
  // expectations
  // ----------------------------------------
  // exclusive end of the summed range in image mode
  function automatic int bound(mem_kind_t m, logic [1:0] c);
    case (c)
      CP_OFF:  return (m == MEM_8K) ? int'(BND_LARGE_OFF) : int'(BND_SMALL_OFF);
      CP_HALF: return (m == MEM_8K) ? int'(BND_8K_HALF) : int'(BND_4K_HALF);
      CP_TOP:  return (m == MEM_8K) ? int'(BND_8K_TOP) : int'(BND_4K_TOP);
      default: return 0;
    endcase
  endfunction
  // full checksum; carries fall off the 16-bit total
  function automatic logic [15:0] expect_sum(mem_kind_t m, logic [1:0] c, logic r, int n, int z,
                                             logic [13:0] b, logic [13:0] cw, logic [15:0] idt);
    logic [15:0] s;
    s = 16'h0000;
    for (int k = 0; k < n; k++) begin
      // the source reads words from z upward as zero, in both modes
      if ((k < z) && (r || (k < bound(m, c)))) begin
        s += 16'(14'(b + 14'(k * 16'h0155)));
      end
    end
    s += 16'(cw & CFG_MASK);
    if (c != CP_OFF) s += idt;
    return s;
  endfunction

  // ----------------------------------------
  // check and close
  // ----------------------------------------
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one sum: drive settings, start, refused restart, stream, compare
  task automatic run_case(mem_kind_t m, logic [1:0] c, logic r, int n, int z, bit pre);
    logic [13:0] cw, i0, i1, i2, i3, b;
    logic [15:0] exp;
    int t;
    cw = {c, 12'($random(seed))};
    i0 = 14'($random(seed));
    i1 = 14'($random(seed));
    i2 = 14'($random(seed));
    i3 = 14'($random(seed));
    b = 14'($random(seed));
    exp = expect_sum(m, c, r, n, z, b, cw, {i0[3:0], i1[3:0], i2[3:0], i3[3:0]});
    @(posedge clk);
    kind <= m;
    rb <= r;
    cfg <= cw;
    base <= b;
    cnt <= 16'(n);
    zf <= 16'(z);
    id0 <= i0;
    id1 <= i1;
    id2 <= i2;
    id3 <= i3;
    stall_en <= !pre;
    if (pre) begin
      load <= 1'b1;
      @(posedge clk) load <= 1'b0;
      repeat (30) @(posedge clk);
      @(negedge clk) check("ready_full", {15'h0000, w_ready}, 16'h0000);
    end
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    @(negedge clk) check("busy", {15'h0000, busy}, 16'h0001);
    @(posedge clk) begin
      cfg <= ~cw;
      start <= 1'b1;
      load <= !pre;
      stall_en <= 1'b1;
    end
    @(posedge clk) begin
      start <= 1'b0;
      load <= 1'b0;
    end
    for (t = 0; t < 20000 && done !== 1'b1; t++) @(negedge clk);
    if (done !== 1'b1) begin
      fail_count++;
      finish_test();
    end
    check("checksum", sum, exp);
    @(negedge clk) check("done_pulse", {15'h0000, done}, 16'h0000);
    check("checksum_hold", sum, exp);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk) check("reset_flags", {13'h0000, busy, done, w_ready}, 16'h0001);
    check("reset_sum", sum, 16'h0000);
    run_case(MEM_8K, CP_OFF, 1'b0, 16'h1804, 16'hFFFF, 1'b0);
    run_case(MEM_2K, CP_OFF, 1'b0, 16'h0803, 16'hFFFF, 1'b0);
    run_case(MEM_4K, CP_ALL, 1'b0, 5, 16'hFFFF, 1'b0);
    run_case(MEM_4K, CP_HALF, 1'b0, 16'h0802, 16'hFFFF, 1'b0);
    run_case(MEM_4K, CP_TOP, 1'b0, 16'h0F01, 16'hFFFF, 1'b0);
    run_case(MEM_8K, CP_HALF, 1'b0, 16'h1001, 16'hFFFF, 1'b0);
    run_case(MEM_8K, CP_TOP, 1'b0, 16'h1F01, 16'hFFFF, 1'b0);
    run_case(MEM_2K, CP_OFF, 1'b1, 16'h0810, 16'h0810, 1'b0);
    run_case(MEM_4K, CP_HALF, 1'b1, 16'h0900, 16'h0800, 1'b0);
    run_case(MEM_4K, CP_OFF, 1'b0, 20, 16'hFFFF, 1'b1);
    run_case(MEM_8K, CP_OFF, 1'b0, 1, 16'hFFFF, 1'b0);
    for (int i = 0; i < 4; i++) begin
      run_case(mem_kind_t'($unsigned($random(seed)) % 3), 2'($random(seed)), 1'($random(seed)),
               1 + $unsigned($random(seed)) % 40, 16'h0010, 1'b0);
    end
    finish_test();
  end
endmodule
`default_nettype wire
